/* iep_pkg.sv */
// Constants, field layouts and carrier types for the interrupt enable and
// priority registers. Assumes an 8-bit special-function-register space.
package iep_pkg;

    // Register addresses
    localparam logic [7:0] IEP_ADDR_BASIC_PRIO   = 8'hb8;
    localparam logic [7:0] IEP_ADDR_EXT_EN_ONE   = 8'he6;
    localparam logic [7:0] IEP_ADDR_EXT_PRIO_ONE = 8'hf6;

    // Reset values
    localparam logic [7:0] IEP_BASIC_PRIO_RST   = 8'h80;
    localparam logic [7:0] IEP_EXT_EN_ONE_RST   = 8'h00;
    localparam logic [7:0] IEP_EXT_PRIO_ONE_RST = 8'h00;

    // Bit that always reads as one in the basic priority register
    localparam int         IEP_BASIC_FIXED_BIT = 7;
    localparam logic       IEP_BASIC_FIXED_VAL = 1'b1;

    // Basic priority register fields
    localparam int IEP_SERIAL_PERIPH_PRIO_BIT = 6;
    localparam int IEP_TIMER_TWO_PRIO_BIT     = 5;
    localparam int IEP_UART_PRIO_BIT          = 4;
    localparam int IEP_TIMER_ONE_PRIO_BIT     = 3;
    localparam int IEP_EXT_IRQ_ONE_PRIO_BIT   = 2;
    localparam int IEP_TIMER_ZERO_PRIO_BIT    = 1;
    localparam int IEP_EXT_IRQ_ZERO_PRIO_BIT  = 0;

    // Extended enable and priority register fields (same layout in both)
    localparam int IEP_TIMER_THREE_BIT    = 7;
    localparam int IEP_COMPARATOR_ONE_BIT = 6;
    localparam int IEP_COMPARATOR_ZERO_BIT = 5;
    localparam int IEP_COUNTER_ARRAY_BIT  = 4;
    localparam int IEP_CONV_DONE_BIT      = 3;
    localparam int IEP_WINDOW_CMP_BIT     = 2;
    localparam int IEP_RTC_IRQ_BIT        = 1;
    localparam int IEP_TWOWIRE_IRQ_BIT    = 0;

    // Source numbering: natural order, lower index wins within a level
    localparam int IEP_NUM_BASIC = 7;
    localparam int IEP_NUM_EXT   = 8;
    localparam int IEP_NUM_SRC   = IEP_NUM_BASIC + IEP_NUM_EXT;
    localparam int IEP_IDX_W     = 4;

    // Peripheral pending flags
    typedef struct packed {
        logic timer_three_high_overflow;
        logic timer_three_low_overflow;
        logic comparator_one_rise_flag;
        logic comparator_one_fall_flag;
        logic comparator_zero_rise_flag;
        logic comparator_zero_fall_flag;
        logic counter_array_req;
        logic conversion_complete_flag;
        logic window_compare_flag;
        logic rtc_alarm_flag;
        logic rtc_osc_failure_flag;
        logic twowire_req;
        logic serial_periph_req;
        logic timer_two_req;
        logic uart_req;
        logic timer_one_req;
        logic ext_irq_one_req;
        logic timer_zero_req;
        logic ext_irq_zero_req;
    } iep_flags_t;

    // Register access from the core
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } iep_sfr_req_t;

    // Service nesting state
    typedef enum logic [1:0] {
        SVC_IDLE,
        SVC_LOW,
        SVC_HIGH,
        SVC_BOTH
    } iep_svc_state_t;

endpackage

/* iep_prio_pick.sv */
// Picks the winning pending source: high level first, then lowest index.
// Assumes request and priority vectors from the same clock domain.
`timescale 1ns/1ns
module iep_prio_pick
    import iep_pkg::*;
(
    // Sources
    input  wire logic [IEP_NUM_SRC-1:0] req,
    input  wire logic [IEP_NUM_SRC-1:0] prio,
    // Winner
    output logic                        found,
    output logic                        high_level,
    output logic [IEP_IDX_W-1:0]        idx
);

    logic [IEP_NUM_SRC-1:0] req_high;

    assign req_high = req & prio;

    always_comb
    begin
        found      = |req;
        high_level = |req_high;
        idx        = '0;
        // Scan downward so the lowest index is kept last
        for (int i = IEP_NUM_SRC - 1; i >= 0; i--)
        begin
            if (high_level ? req_high[i] : req[i])
            begin
                idx = IEP_IDX_W'(i);
            end
        end
    end

endmodule

/* iep_svc_track.sv */
// Tracks which priority levels have a service routine running.
// Assumes the core pulses ack on vectoring and done after return plus one.
`timescale 1ns/1ns
module iep_svc_track
    import iep_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Core events
    input  wire logic irq_ack,
    input  wire logic ack_high,
    input  wire logic svc_done,
    // Levels in service
    output logic      svc_low,
    output logic      svc_high
);

    iep_svc_state_t state_q;
    iep_svc_state_t state_d;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            SVC_IDLE:
            begin
                if (irq_ack)
                begin
                    state_d = ack_high ? SVC_HIGH : SVC_LOW;
                end
            end
            SVC_LOW:
            begin
                if (irq_ack && ack_high)
                begin
                    state_d = SVC_BOTH;
                end
                else if (svc_done)
                begin
                    state_d = SVC_IDLE;
                end
            end
            SVC_HIGH:
            begin
                if (svc_done)
                begin
                    state_d = SVC_IDLE;
                end
            end
            SVC_BOTH:
            begin
                if (svc_done)
                begin
                    state_d = SVC_LOW;
                end
            end
            default:
            begin
                state_d = SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= SVC_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign svc_low  = (state_q == SVC_LOW) || (state_q == SVC_BOTH);
    assign svc_high = (state_q == SVC_HIGH) || (state_q == SVC_BOTH);

endmodule

/* iep_regs.sv */
// Interrupt enable and priority registers with pending decode.
// Assumes peripheral flags and core strobes on core_clk; global and basic
// enables come from the separate interrupt enable register.
//
// Operation
// R1: Basic priority top bit reads one, ignores writes
// R2: Basic bit 6 sets serial peripheral priority
// R3: Basic bit 5 sets timer two priority
// R4: Basic bit 4 sets UART priority
// R5: Basic bit 3 sets timer one priority
// R6: Basic bit 2 sets external interrupt one priority
// R7: Basic bit 1 sets timer zero priority
// R8: Basic bit 0 sets external interrupt zero priority
// R9: Enable bit 7 gates both timer three flags
// R10: Enable bit 6 gates comparator one edges
// R11: Enable bit 5 gates comparator zero edges
// R12: Enable bit 4 gates counter array requests
// R13: Enable bit 3 gates conversion complete flag
// R14: Enable bit 2 gates window compare flag
// R15: Enable bit 1 gates alarm and oscillator failure
// R16: Enable bit 0 gates two-wire bus requests
// R17: Priority bit 7 sets timer three level
// R18: Priority bit 6 sets comparator one level
// R19: Priority bits 5..0 set remaining extended levels
// R20: Global enable overrides every individual mask
// R21: Hold new request while equal-or-higher served
// R22: Sample and decode pending every cycle
`timescale 1ns/1ns
module iep_regs
    import iep_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    // Register access
    input  wire iep_sfr_req_t           sfr_req,
    output logic [7:0]                  sfr_rdata,
    // Enables held in the interrupt enable register
    input  wire logic                   global_irq_enable,
    input  wire logic [IEP_NUM_BASIC-1:0] basic_enable,
    // Peripheral flags
    input  wire iep_flags_t             flags,
    // Core interrupt handshake
    input  wire logic                   irq_ack,
    input  wire logic                   svc_done,
    output logic                        irq_req,
    output logic                        irq_high_level,
    output logic [IEP_IDX_W-1:0]        irq_src_idx,
    // Status to the decoder
    output logic [IEP_NUM_SRC-1:0]      src_pending,
    output logic [IEP_NUM_SRC-1:0]      src_prio
);

    // Register match helper
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        addr_hit = (a == reg_addr);
    endfunction

    // Register state
    logic [6:0]             basic_prio_q;
    logic [6:0]             basic_prio_d;
    logic [7:0]             ext_en_one_q;
    logic [7:0]             ext_en_one_d;
    logic [7:0]             ext_prio_one_q;
    logic [7:0]             ext_prio_one_d;
    logic [7:0]             rdata_q;
    logic [7:0]             rdata_d;

    // Decode state
    logic [IEP_NUM_SRC-1:0] raw_req;
    logic [IEP_NUM_SRC-1:0] en_vec;
    logic [IEP_NUM_SRC-1:0] gated_req;
    logic [IEP_NUM_SRC-1:0] prio_vec;
    logic [IEP_NUM_SRC-1:0] pend_q;
    logic [IEP_NUM_SRC-1:0] pend_d;
    logic [IEP_NUM_SRC-1:0] prio_q;
    logic [IEP_NUM_SRC-1:0] prio_d;
    logic                   pick_found;
    logic                   pick_high;
    logic [IEP_IDX_W-1:0]   pick_idx;
    logic                   win_found_q;
    logic                   win_found_d;
    logic                   win_high_q;
    logic                   win_high_d;
    logic [IEP_IDX_W-1:0]   win_idx_q;
    logic [IEP_IDX_W-1:0]   win_idx_d;
    logic                   svc_low;
    logic                   svc_high;
    logic [7:0]             basic_read;

    // Register writes
    always_comb
    begin
        basic_prio_d   = basic_prio_q;
        ext_en_one_d   = ext_en_one_q;
        ext_prio_one_d = ext_prio_one_q;
        if (sfr_req.wr)
        begin
            if (addr_hit(sfr_req.addr, IEP_ADDR_BASIC_PRIO))
            begin
                // R1: top bit dropped
                basic_prio_d = sfr_req.wdata[6:0];
            end
            if (addr_hit(sfr_req.addr, IEP_ADDR_EXT_EN_ONE))
            begin
                ext_en_one_d = sfr_req.wdata;
            end
            if (addr_hit(sfr_req.addr, IEP_ADDR_EXT_PRIO_ONE))
            begin
                ext_prio_one_d = sfr_req.wdata;
            end
        end
    end

    // R1: fixed one on read
    always_comb
    begin
        basic_read                      = {1'b0, basic_prio_q};
        basic_read[IEP_BASIC_FIXED_BIT] = IEP_BASIC_FIXED_VAL;
    end

    // Register reads, unmapped addresses read zero
    always_comb
    begin
        rdata_d = rdata_q;
        if (sfr_req.rd)
        begin
            if (addr_hit(sfr_req.addr, IEP_ADDR_BASIC_PRIO))
            begin
                rdata_d = basic_read;
            end
            else if (addr_hit(sfr_req.addr, IEP_ADDR_EXT_EN_ONE))
            begin
                rdata_d = ext_en_one_q;
            end
            else if (addr_hit(sfr_req.addr, IEP_ADDR_EXT_PRIO_ONE))
            begin
                rdata_d = ext_prio_one_q;
            end
            else
            begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            basic_prio_q   <= IEP_BASIC_PRIO_RST[6:0];
            ext_en_one_q   <= IEP_EXT_EN_ONE_RST;
            ext_prio_one_q <= IEP_EXT_PRIO_ONE_RST;
            rdata_q        <= 8'h00;
        end
        else
        begin
            basic_prio_q   <= basic_prio_d;
            ext_en_one_q   <= ext_en_one_d;
            ext_prio_one_q <= ext_prio_one_d;
            rdata_q        <= rdata_d;
        end
    end

    // Raw requests in source order
    always_comb
    begin
        raw_req     = '0;
        raw_req[0]  = flags.ext_irq_zero_req;
        raw_req[1]  = flags.timer_zero_req;
        raw_req[2]  = flags.ext_irq_one_req;
        raw_req[3]  = flags.timer_one_req;
        raw_req[4]  = flags.uart_req;
        raw_req[5]  = flags.timer_two_req;
        raw_req[6]  = flags.serial_periph_req;
        // R16: two-wire bus source
        raw_req[IEP_NUM_BASIC + IEP_TWOWIRE_IRQ_BIT] = flags.twowire_req;
        // R15: alarm or oscillator failure
        raw_req[IEP_NUM_BASIC + IEP_RTC_IRQ_BIT] =
            flags.rtc_alarm_flag | flags.rtc_osc_failure_flag;
        // R14: window compare source
        raw_req[IEP_NUM_BASIC + IEP_WINDOW_CMP_BIT] = flags.window_compare_flag;
        // R13: conversion complete source
        raw_req[IEP_NUM_BASIC + IEP_CONV_DONE_BIT] = flags.conversion_complete_flag;
        // R12: counter array source
        raw_req[IEP_NUM_BASIC + IEP_COUNTER_ARRAY_BIT] = flags.counter_array_req;
        // R11: comparator zero either edge
        raw_req[IEP_NUM_BASIC + IEP_COMPARATOR_ZERO_BIT] =
            flags.comparator_zero_rise_flag | flags.comparator_zero_fall_flag;
        // R10: comparator one either edge
        raw_req[IEP_NUM_BASIC + IEP_COMPARATOR_ONE_BIT] =
            flags.comparator_one_rise_flag | flags.comparator_one_fall_flag;
        // R9: timer three either overflow
        raw_req[IEP_NUM_BASIC + IEP_TIMER_THREE_BIT] =
            flags.timer_three_low_overflow | flags.timer_three_high_overflow;
    end

    // R9: extended enables gate sources 7..14
    assign en_vec = {ext_en_one_q, basic_enable};

    // R20: global enable over all masks
    assign gated_req = global_irq_enable ? (raw_req & en_vec) : '0;

    // Priority map per source
    always_comb
    begin
        prio_vec = '0;
        // R8: external interrupt zero level
        prio_vec[0] = basic_prio_q[IEP_EXT_IRQ_ZERO_PRIO_BIT];
        // R7: timer zero level
        prio_vec[1] = basic_prio_q[IEP_TIMER_ZERO_PRIO_BIT];
        // R6: external interrupt one level
        prio_vec[2] = basic_prio_q[IEP_EXT_IRQ_ONE_PRIO_BIT];
        // R5: timer one level
        prio_vec[3] = basic_prio_q[IEP_TIMER_ONE_PRIO_BIT];
        // R4: UART level
        prio_vec[4] = basic_prio_q[IEP_UART_PRIO_BIT];
        // R3: timer two level
        prio_vec[5] = basic_prio_q[IEP_TIMER_TWO_PRIO_BIT];
        // R2: serial peripheral level
        prio_vec[6] = basic_prio_q[IEP_SERIAL_PERIPH_PRIO_BIT];
        // R19: lower extended levels
        for (int b = 0; b <= IEP_COMPARATOR_ZERO_BIT; b++)
        begin
            prio_vec[IEP_NUM_BASIC + b] = ext_prio_one_q[b];
        end
        // R18: comparator one level
        prio_vec[IEP_NUM_BASIC + IEP_COMPARATOR_ONE_BIT] =
            ext_prio_one_q[IEP_COMPARATOR_ONE_BIT];
        // R17: timer three level
        prio_vec[IEP_NUM_BASIC + IEP_TIMER_THREE_BIT] =
            ext_prio_one_q[IEP_TIMER_THREE_BIT];
    end

    // R22: sample pending every cycle
    always_comb
    begin
        pend_d = gated_req;
        prio_d = prio_vec;
    end

    iep_prio_pick u_pick (
        .req        (pend_q),
        .prio       (prio_q),
        .found      (pick_found),
        .high_level (pick_high),
        .idx        (pick_idx)
    );

    // R22: decode winner every cycle
    always_comb
    begin
        win_found_d = pick_found;
        win_high_d  = pick_high;
        win_idx_d   = pick_idx;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pend_q      <= '0;
            prio_q      <= '0;
            win_found_q <= 1'b0;
            win_high_q  <= 1'b0;
            win_idx_q   <= '0;
        end
        else
        begin
            pend_q      <= pend_d;
            prio_q      <= prio_d;
            win_found_q <= win_found_d;
            win_high_q  <= win_high_d;
            win_idx_q   <= win_idx_d;
        end
    end

    iep_svc_track u_svc (
        .core_clk (core_clk),
        .rst      (rst),
        .irq_ack  (irq_ack & irq_req),
        .ack_high (win_high_q),
        .svc_done (svc_done),
        .svc_low  (svc_low),
        .svc_high (svc_high)
    );

    // R21: hold while equal or higher served
    assign irq_req = win_found_q && !svc_high && (win_high_q || !svc_low);

    assign irq_high_level = win_high_q;
    assign irq_src_idx    = win_idx_q;
    assign src_pending    = pend_q;
    assign src_prio       = prio_q;
    assign sfr_rdata      = rdata_q;

endmodule

/* iep_core_model.sv */
// Behavioural core: takes requests and finishes service routines.
// Assumes irq_req settles after the rising edge; drives on the falling edge.
`timescale 1ns/1ns
module iep_core_model
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Control from the bench
    input  wire logic       accept,
    input  wire logic [3:0] svc_len,
    // Interrupt handshake
    input  wire logic       irq_req,
    output logic            irq_ack,
    output logic            svc_done
);
    int depth;
    int cnt;

    always @(negedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_ack  <= 1'b0;
            svc_done <= 1'b0;
            depth    <= 0;
            cnt      <= 0;
        end
        else
        begin
            irq_ack  <= 1'b0;
            svc_done <= 1'b0;
            if (irq_ack || svc_done)
                cnt <= cnt;
            else if (irq_req && accept)
            begin
                irq_ack <= 1'b1;
                depth   <= depth + 1;
                cnt     <= svc_len;
            end
            else if (depth > 0 && cnt == 0)
            begin
                svc_done <= 1'b1;
                depth    <= depth - 1;
                cnt      <= svc_len;
            end
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule

/* iep_regs_asserts.sv */
// Checker for the interrupt enable and priority registers.
// Assumes it is bound to iep_regs and sees only its ports.
`timescale 1ns/1ns
module iep_regs_asserts
    import iep_pkg::*;
(
    // Clock and reset
    input wire logic                     core_clk,
    input wire logic                     rst,
    // Register access
    input wire iep_sfr_req_t             sfr_req,
    input wire logic [7:0]               sfr_rdata,
    // Enables and flags
    input wire logic                     global_irq_enable,
    input wire logic [IEP_NUM_BASIC-1:0] basic_enable,
    input wire iep_flags_t               flags,
    // Core handshake
    input wire logic                     irq_ack,
    input wire logic                     svc_done,
    input wire logic                     irq_req,
    input wire logic                     irq_high_level,
    input wire logic [IEP_IDX_W-1:0]     irq_src_idx,
    input wire logic [IEP_NUM_SRC-1:0]   src_pending,
    input wire logic [IEP_NUM_SRC-1:0]   src_prio
);
    logic [7:0]  bp_q, bp_d, en_q, en_d, xp_q, xp_d, ext_x;
    logic [14:0] pend_q, prio_q;

    // Merged multi-flag sources, extended order
    assign ext_x = {flags[18] | flags[17], flags[16] | flags[15], flags[14] | flags[13],
                    flags[12], flags[11], flags[10], flags[9] | flags[8], flags[7]};

    always_comb
    begin
        bp_d = bp_q;
        en_d = en_q;
        xp_d = xp_q;
        if (sfr_req.wr && sfr_req.addr == IEP_ADDR_BASIC_PRIO)
            bp_d = sfr_req.wdata;
        if (sfr_req.wr && sfr_req.addr == IEP_ADDR_EXT_EN_ONE)
            en_d = sfr_req.wdata;
        if (sfr_req.wr && sfr_req.addr == IEP_ADDR_EXT_PRIO_ONE)
            xp_d = sfr_req.wdata;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bp_q   <= IEP_BASIC_PRIO_RST;
            en_q   <= IEP_EXT_EN_ONE_RST;
            xp_q   <= IEP_EXT_PRIO_ONE_RST;
            pend_q <= '0;
            prio_q <= '0;
        end
        else
        begin
            bp_q   <= bp_d;
            en_q   <= en_d;
            xp_q   <= xp_d;
            pend_q <= src_pending;
            prio_q <= src_prio;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_high_ack;
        irq_req && irq_ack && irq_high_level;
    endsequence
    sequence s_low_ack;
        irq_req && irq_ack && !irq_high_level;
    endsequence

    a_top_bit_one: assert property (
        sfr_req.rd && sfr_req.addr == IEP_ADDR_BASIC_PRIO |=> sfr_rdata[7])
        else $error("basic priority top bit read as zero");
    a_enable_readback: assert property (
        sfr_req.rd && sfr_req.addr == IEP_ADDR_EXT_EN_ONE |=> sfr_rdata == $past(en_q))
        else $error("extended enable read back wrong");
    a_prio_vector: assert property (
        1'b1 |=> src_prio == $past({xp_q, bp_q[6:0]}))
        else $error("priority vector differs from registers");
    a_basic_gate: assert property (
        1'b1 |=> src_pending[6:0] == $past(flags[6:0] & basic_enable & {7{global_irq_enable}}))
        else $error("basic pending gating wrong");
    a_ext_gate: assert property (
        1'b1 |=> src_pending[14:7] == $past(ext_x & en_q & {8{global_irq_enable}}))
        else $error("extended pending gating wrong");
    a_winner_valid: assert property (
        irq_req |-> pend_q[irq_src_idx] && irq_high_level == prio_q[irq_src_idx])
        else $error("presented source not pending or wrong level");
    a_high_first: assert property (
        irq_req && !irq_high_level |-> (pend_q & prio_q) == 15'h0000)
        else $error("low source presented over high");
    a_high_hold: assert property (
        s_high_ack ##1 !svc_done |-> !irq_req ##1 !irq_req)
        else $error("request during high service");
    a_low_hold: assert property (
        s_low_ack |=> !irq_req || irq_high_level)
        else $error("low request during low service");
endmodule

bind iep_regs iep_regs_asserts chk_u (.core_clk, .rst, .sfr_req, .sfr_rdata,
    .global_irq_enable, .basic_enable, .flags, .irq_ack, .svc_done, .irq_req,
    .irq_high_level, .irq_src_idx, .src_pending, .src_prio);

/* tb.sv */
// Self-checking bench for the interrupt enable and priority registers.
// Assumes iep_regs, its bound checker and the behavioural core model.
`timescale 1ns/1ns
module tb;
    import iep_pkg::*;
    logic         core_clk = 1'b0;
    logic         rst = 1'b1;
    iep_sfr_req_t sfr_req = '0;
    logic         global_irq_enable = 1'b0;
    logic [6:0]   basic_enable = '0;
    iep_flags_t   flags = '0;
    logic         accept = 1'b0;
    logic [3:0]   svc_len = 4'h0;
    logic         irq_ack, svc_done, irq_req, irq_high_level;
    logic [3:0]   irq_src_idx;
    logic [7:0]   sfr_rdata, m_bp, m_en, m_xp, exp_rd;
    logic [14:0]  src_pending, src_prio, m_pend, m_pq;
    logic         m_lvl, m_sl, m_sh, rd_pend = 1'b0;
    int           failures = 0, n_tests = 0, m_win, w;
    int           seed = 32'hfe60_eab7;
    logic [7:0]   addr_tbl [4] = '{8'hb8, 8'he6, 8'hf6, 8'hb9};
    wire [14:0]   m_prio = {m_xp, m_bp[6:0]};
    wire          exp_req = m_win >= 0 && !m_sh && !(m_sl && !m_lvl);

    always #5 core_clk = ~core_clk;

    iep_regs dut_u (.core_clk, .rst, .sfr_req, .sfr_rdata, .global_irq_enable,
        .basic_enable, .flags, .irq_ack, .svc_done, .irq_req, .irq_high_level,
        .irq_src_idx, .src_pending, .src_prio);
    iep_core_model core_u (.core_clk, .rst, .accept, .svc_len, .irq_req, .irq_ack,
        .svc_done);

    function automatic logic [14:0] gate();
        logic [7:0] x;
        x = {flags[18] | flags[17], flags[16] | flags[15], flags[14] | flags[13],
             flags[12], flags[11], flags[10], flags[9] | flags[8], flags[7]};
        return global_irq_enable ? {x & m_en, flags[6:0] & basic_enable} : 15'h0000;
    endfunction

    function automatic int win(logic [14:0] p, logic [14:0] pr);
        for (int i = 0; i < 15; i++)
            if (p[i] && pr[i])
                return i;
        for (int i = 0; i < 15; i++)
            if (p[i])
                return i;
        return -1;
    endfunction

    function automatic logic [7:0] rd_val(logic [7:0] a);
        case (a)
            IEP_ADDR_BASIC_PRIO:   return m_bp | 8'h80;
            IEP_ADDR_EXT_EN_ONE:   return m_en;
            IEP_ADDR_EXT_PRIO_ONE: return m_xp;
            default:               return 8'h00;
        endcase
    endfunction

    // Reference model of registers, gating, winner and service levels
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            m_bp   <= IEP_BASIC_PRIO_RST;
            m_en   <= IEP_EXT_EN_ONE_RST;
            m_xp   <= IEP_EXT_PRIO_ONE_RST;
            m_pend <= '0;
            m_pq   <= '0;
            m_win  <= -1;
            m_lvl  <= 1'b0;
            m_sl   <= 1'b0;
            m_sh   <= 1'b0;
        end
        else
        begin
            w = win(m_pend, m_pq);
            m_win  <= w;
            m_lvl  <= (w >= 0) && m_pq[w];
            m_pend <= gate();
            m_pq   <= m_prio;
            if (irq_ack && exp_req)
            begin
                if (m_lvl)
                    m_sh <= 1'b1;
                else
                    m_sl <= 1'b1;
            end
            if (svc_done)
            begin
                if (m_sh)
                    m_sh <= 1'b0;
                else
                    m_sl <= 1'b0;
            end
            if (sfr_req.wr)
            begin
                case (sfr_req.addr)
                    IEP_ADDR_BASIC_PRIO:   m_bp <= sfr_req.wdata;
                    IEP_ADDR_EXT_EN_ONE:   m_en <= sfr_req.wdata;
                    IEP_ADDR_EXT_PRIO_ONE: m_xp <= sfr_req.wdata;
                    default:               ;
                endcase
            end
        end
    end

    task automatic bad(string what);
        failures++;
        $display("unexpected at %0t: %s", $time, what);
    endtask

    task automatic cmp_rd(logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp)
            bad("read data");
    endtask

    task automatic cmp_vec(logic [14:0] got, logic [14:0] exp);
        n_tests++;
        if (got !== exp)
            bad("source vector");
    endtask

    task automatic cmp_irq();
        n_tests++;
        if (irq_req !== exp_req)
            bad("request level");
        else if (m_win >= 0 && {irq_src_idx, irq_high_level} !== {m_win[3:0], m_lvl})
            bad("winner");
    endtask

    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Random traffic on flags, enables and registers; check every cycle
    task automatic run(int n, logic acc);
        accept = acc;
        repeat (n)
        begin
            @(negedge core_clk);
            if (rd_pend)
                cmp_rd(sfr_rdata, exp_rd);
            cmp_vec(src_pending, m_pend);
            cmp_vec(src_prio, m_pq);
            cmp_irq();
            flags = 19'($random(seed) & $random(seed));
            basic_enable = 7'($random(seed));
            global_irq_enable = ($random(seed) & 3) != 0;
            svc_len = 4'($random(seed));
            sfr_req.addr = addr_tbl[$random(seed) & 3];
            sfr_req.wdata = 8'($random(seed));
            sfr_req.wr = ($random(seed) & 3) == 0;
            sfr_req.rd = ($random(seed) & 3) == 0;
            rd_pend = sfr_req.rd;
            exp_rd = rd_val(sfr_req.addr);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        sfr_req.rd = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            sfr_req.addr = addr_tbl[k];
            exp_rd = rd_val(addr_tbl[k]);
            @(negedge core_clk);
            cmp_rd(sfr_rdata, exp_rd);
        end
        sfr_req.rd = 1'b0;
        run(300, 1'b0);
        run(700, 1'b1);
        test_done();
    end

    initial
    begin
        #20000;
        failures++;
        test_done();
    end
endmodule
